// ===== shared/lane_steer_defs.vh
// Constants for the external memory data lane steering block
// How it works
// [R1] Data accesses only to 32- or 16-bit memory
// [R2] 32-bit data uses two 16-bit buses
// [R3] 16/8-bit data uses one 16-bit bus
// [R4] 32-wide: address 21-2, 32-bit uses all lanes
// [R5] Address bit 1 swaps word lanes on 32-wide
// [R6] DMA puts 32-bit MSW at even address
// [R7] 32-bit on 16-wide: two consecutive low transfers
// [R8] Second address is first plus or minus one
// [R9] 16-wide: address 21-1, low enables only
// [R10] 16-bit write one word, read full width; on 32-wide the code enables only the half picked by bit 1 for reads too
// [R11] 16-bit on 32-wide: bit 1 picks half
// [R12] Byte write one byte, read like 16-bit
// [R13] Byte write 32-wide: bits 1-0 pick lane
// [R14] Byte write 16-wide: bit 0 picks lane
// [R15] Memory type code sets bus width
// [R16] Read data returned in low positions
`ifndef LANE_STEER_DEFS_VH
`define LANE_STEER_DEFS_VH

// Memory type codes
`define MEM_TYPE_ASYNC8 3'h0
`define MEM_TYPE_ASYNC16 3'h1
`define MEM_TYPE_ASYNC32 3'h2
`define MEM_TYPE_SDRAM32 3'h3
`define MEM_TYPE_SBSRAM32 3'h4

// Access size codes
`define SIZE_BYTE 2'h0
`define SIZE_HALF 2'h1
`define SIZE_WORD 2'h2

// Byte-lane enable patterns, active low
`define LANES_ALL 4'h0
`define LANES_NONE 4'hf
`define LANES_UPPER 4'h3
`define LANES_LOWER 4'hc

// Response entry layout: {write, error, hi, lo}
`define RSP_WIDTH 34
`define RSP_WRITE_BIT 33
`define RSP_ERROR_BIT 32

`endif

// ===== rtl/two_entry_buffer.v
// Two-entry buffer with valid and ready on both sides
`default_nettype none
module two_entry_buffer #(
   parameter WIDTH = 34
) (
   input wire sys_clk,
   input wire reset_n,
   input wire in_valid,
   output reg in_ready,
   input wire [WIDTH-1:0] in_data,
   output reg out_valid,
   input wire out_ready,
   output reg [WIDTH-1:0] out_data
);
   reg [WIDTH-1:0] tail;
   reg [1:0] count;
   reg [1:0] next_count;
   wire push;
   wire pop;

   assign push = in_valid & in_ready;
   assign pop = out_valid & out_ready;

   always @* begin
      next_count = count;
      if (push && !pop) begin
         next_count = count + 2'h1;
      end else if (pop && !push) begin
         next_count = count - 2'h1;
      end
   end

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         count <= 2'h0;
         in_ready <= 1'b0;
         out_valid <= 1'b0;
         out_data <= {WIDTH{1'b0}};
         tail <= {WIDTH{1'b0}};
      end else begin
         count <= next_count;
         in_ready <= (next_count != 2'h2);
         out_valid <= (next_count != 2'h0);
         if (push && !pop) begin
            if (count == 2'h0) begin
               out_data <= in_data;
            end else begin
               tail <= in_data;
            end
         end else if (pop && !push) begin
            out_data <= tail;
         end else if (push && pop) begin
            if (count == 2'h1) begin
               out_data <= in_data;
            end else begin
               out_data <= tail;
               tail <= in_data;
            end
         end
      end
   end
endmodule // two_entry_buffer
`default_nettype wire

// ===== rtl/lane_steering.v
// Data lane steering between processor buses and external memory
`include "lane_steer_defs.vh"
`default_nettype none
module lane_steering (
   input wire sys_clk,
   input wire reset_n,
   input wire [2:0] memory_type_select,
   input wire req_valid,
   output reg req_ready,
   input wire req_write,
   input wire [1:0] req_size,
   input wire [21:0] req_addr,
   input wire [15:0] req_wdata_hi,
   input wire [15:0] req_wdata_lo,
   output wire rsp_valid,
   input wire rsp_ready,
   output wire rsp_write,
   output wire rsp_error,
   output wire [15:0] rsp_data_hi,
   output wire [15:0] rsp_data_lo,
   output reg mem_strobe,
   output reg mem_write,
   output reg [21:0] mem_addr,
   output reg [3:0] byte_lane_enable_n,
   output reg [31:0] mem_data_out,
   output reg mem_data_oe,
   input wire [31:0] mem_data_in,
   input wire mem_ack
);
   localparam ST_IDLE = 2'h0;
   localparam ST_WAIT = 2'h1;
   localparam ST_PUSH = 2'h2;

   reg [1:0] state;
   reg wide32;
   reg [1:0] size;
   reg a1;
   reg a0;
   reg second;
   reg err;
   reg [15:0] hold_lo;
   reg [15:0] ret_hi;
   reg [15:0] ret_lo;
   reg ack_meta;
   reg ack_sync;
   reg ack_prev;
   reg [31:0] data_meta;
   reg [31:0] data_sync;
   reg buf_push;
   wire buf_ready;
   wire [`RSP_WIDTH-1:0] buf_out;
   wire ack_rise;
   wire type_ok;
   wire type_w32;
   wire [15:0] sel_half;
   wire [7:0] sel_byte;

   // Lane enables for one transfer of the given shape
   function [3:0] lane_enables;
      input w32;
      input [1:0] sz;
      input wr;
      input b1;
      input b0;
      begin
         lane_enables = `LANES_NONE;
         if (!w32) begin
            if (sz == `SIZE_BYTE && wr) begin // see [R14]
               lane_enables = b0 ? 4'he : 4'hd;
            end else begin
               lane_enables = `LANES_LOWER; // see [R9]
            end
         end else if (sz == `SIZE_WORD) begin
            lane_enables = `LANES_ALL; // see [R4]
         end else if (sz == `SIZE_BYTE && wr) begin
            case ({b1, b0}) // see [R13]
               2'h0: lane_enables = 4'h7;
               2'h1: lane_enables = 4'hb;
               2'h2: lane_enables = 4'hd;
               default: lane_enables = 4'he;
            endcase
         end else begin
            lane_enables = b1 ? `LANES_LOWER : `LANES_UPPER; // see [R11]
         end
      end
   endfunction

   // Memory type to bus width
   assign type_w32 = (memory_type_select == `MEM_TYPE_ASYNC32) ||
      (memory_type_select == `MEM_TYPE_SDRAM32) ||
      (memory_type_select == `MEM_TYPE_SBSRAM32); // see [R15]
   assign type_ok = type_w32 ||
      (memory_type_select == `MEM_TYPE_ASYNC16); // see [R1]

   assign ack_rise = ack_sync & ~ack_prev;

   // Word and byte isolation from the fetched memory width
   assign sel_half = (wide32 && !a1) ? data_sync[31:16] : data_sync[15:0];
   assign sel_byte = a0 ? sel_half[7:0] : sel_half[15:8];

   // Pin inputs through two flip-flops
   always @(posedge sys_clk) begin
      if (!reset_n) begin
         ack_meta <= 1'b0;
         ack_sync <= 1'b0;
         ack_prev <= 1'b0;
         data_meta <= 32'h0;
         data_sync <= 32'h0;
      end else begin
         ack_meta <= mem_ack;
         ack_sync <= ack_meta;
         ack_prev <= ack_sync;
         data_meta <= mem_data_in;
         data_sync <= data_meta;
      end
   end

   always @(posedge sys_clk) begin
      if (!reset_n) begin
         state <= ST_IDLE;
         req_ready <= 1'b0;
         wide32 <= 1'b0;
         size <= `SIZE_BYTE;
         a1 <= 1'b0;
         a0 <= 1'b0;
         second <= 1'b0;
         err <= 1'b0;
         hold_lo <= 16'h0;
         ret_hi <= 16'h0;
         ret_lo <= 16'h0;
         buf_push <= 1'b0;
         mem_strobe <= 1'b0;
         mem_write <= 1'b0;
         mem_addr <= 22'h0;
         byte_lane_enable_n <= `LANES_NONE;
         mem_data_out <= 32'h0;
         mem_data_oe <= 1'b0;
      end else begin
         mem_strobe <= 1'b0;
         buf_push <= 1'b0;
         case (state)
            ST_IDLE: begin
               req_ready <= 1'b1;
               if (req_valid && req_ready) begin
                  req_ready <= 1'b0;
                  wide32 <= type_w32;
                  size <= req_size;
                  a1 <= req_addr[1];
                  a0 <= req_addr[0];
                  second <= 1'b0;
                  mem_write <= req_write;
                  hold_lo <= req_wdata_lo;
                  ret_hi <= 16'h0;
                  ret_lo <= 16'h0;
                  if (!type_ok || req_size > `SIZE_WORD) begin
                     // Unsupported width or size ends with an error answer
                     err <= 1'b1; // see [R1]
                     state <= ST_PUSH;
                  end else begin
                     err <= 1'b0;
                     mem_strobe <= 1'b1;
                     mem_data_oe <= req_write;
                     byte_lane_enable_n <= lane_enables(type_w32, req_size,
                        req_write, req_addr[1], req_addr[0]);
                     state <= ST_WAIT;
                     if (type_w32) begin
                        mem_addr <= {req_addr[21:2], 2'h0}; // see [R4]
                        if (req_size == `SIZE_WORD) begin
                           // Upper lanes carry the even word
                           mem_data_out <= req_addr[1] ?
                              {req_wdata_lo, req_wdata_hi} :
                              {req_wdata_hi, req_wdata_lo}; // see [R2] [R5]
                        end else if (req_size == `SIZE_HALF) begin
                           mem_data_out <= {req_wdata_lo, req_wdata_lo}; // see [R3] [R10]
                        end else begin
                           mem_data_out <= {4{req_wdata_lo[7:0]}}; // see [R12]
                        end
                     end else begin
                        mem_addr <= {req_addr[21:1], 1'b0}; // see [R9]
                        if (req_size == `SIZE_WORD) begin
                           // First transfer carries the most significant word
                           mem_data_out <= {16'h0, req_wdata_hi}; // see [R7]
                        end else if (req_size == `SIZE_HALF) begin
                           mem_data_out <= {16'h0, req_wdata_lo};
                        end else begin
                           mem_data_out <= {16'h0, {2{req_wdata_lo[7:0]}}}; // see [R14]
                        end
                     end
                  end
               end
            end
            ST_WAIT: begin
               if (ack_rise) begin
                  if (!wide32 && size == `SIZE_WORD && !second) begin
                     // Start the least significant word right away
                     second <= 1'b1;
                     // Data pins mean nothing while the block drives a write
                     ret_hi <= mem_write ? 16'h0 : data_sync[15:0];
                     mem_strobe <= 1'b1;
                     mem_data_out <= {16'h0, hold_lo}; // see [R7]
                     if (a1) begin
                        mem_addr <= {mem_addr[21:1] - 21'h1, 1'b0}; // see [R8]
                     end else begin
                        mem_addr <= {mem_addr[21:1] + 21'h1, 1'b0}; // see [R8]
                     end
                  end else begin
                     mem_data_oe <= 1'b0;
                     byte_lane_enable_n <= `LANES_NONE;
                     state <= ST_PUSH;
                     if (mem_write) begin
                        // Write answers carry zero data
                        ret_lo <= 16'h0;
                     end else if (size == `SIZE_WORD) begin
                        if (!wide32) begin
                           ret_lo <= data_sync[15:0]; // see [R2]
                        end else if (a1) begin
                           ret_hi <= data_sync[15:0]; // see [R5]
                           ret_lo <= data_sync[31:16];
                        end else begin
                           ret_hi <= data_sync[31:16];
                           ret_lo <= data_sync[15:0];
                        end
                     end else if (size == `SIZE_HALF) begin
                        ret_lo <= sel_half; // see [R10] [R16]
                     end else begin
                        ret_lo <= {8'h0, sel_byte}; // see [R12] [R16]
                     end
                  end
               end
            end
            ST_PUSH: begin
               mem_data_oe <= 1'b0;
               byte_lane_enable_n <= `LANES_NONE;
               // Hold the answer until the buffer has room
               if (buf_ready && !buf_push) begin
                  buf_push <= 1'b1;
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   two_entry_buffer #(
      .WIDTH(`RSP_WIDTH)
   ) answer_buffer (
      .sys_clk(sys_clk),
      .reset_n(reset_n),
      .in_valid(buf_push),
      .in_ready(buf_ready),
      .in_data({mem_write, err, ret_hi, ret_lo}),
      .out_valid(rsp_valid),
      .out_ready(rsp_ready),
      .out_data(buf_out)
   );

   assign rsp_write = buf_out[`RSP_WRITE_BIT];
   assign rsp_error = buf_out[`RSP_ERROR_BIT];
   assign rsp_data_hi = buf_out[31:16];
   assign rsp_data_lo = buf_out[15:0];
endmodule // lane_steering
`default_nettype wire

// ===== tb/lane_mem_model.sv
// Behavioural external memory that answers each strobe with a delayed ack
`default_nettype none
module lane_mem_model (
   input wire logic sys_clk,
   input wire logic wide,
   input wire logic mem_strobe,
   input wire logic mem_write,
   input wire logic [21:0] mem_addr,
   input wire logic [3:0] byte_lane_enable_n,
   input wire logic [31:0] mem_data_out,
   output logic [31:0] mem_data_in,
   output logic mem_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] m [0:255];
   logic [31:0] d;
   int lat = 1;
   initial begin
      mem_ack = 1'b0;
      mem_data_in = 32'h0;
      foreach (m[k]) m[k] = 8'(k);
   end
   // Lane 3 holds the lowest byte address on a 32-wide part, lane 1 on a 16-wide one
   always @(posedge sys_clk) begin
      if (mem_strobe) begin
         for (int i = 0; i < 4; i++) begin
            if (mem_write && !byte_lane_enable_n[i]) begin
               m[mem_addr[7:0] + (wide ? 3 - i : 1 - i)] = mem_data_out[8*i +: 8];
            end
            if (wide || i < 2) begin
               d[8*i +: 8] = m[mem_addr[7:0] + (wide ? 3 - i : 1 - i)];
            end
         end
         if (!wide) begin
            d[31:16] = ~d[15:0];
         end
         repeat (lat) @(posedge sys_clk);
         mem_data_in <= d;
         mem_ack <= 1'b1;
         repeat (3) @(posedge sys_clk);
         mem_ack <= 1'b0;
         mem_data_in <= ~d;
      end
   end
endmodule // lane_mem_model
`default_nettype wire

// ===== tb/lane_steering_checker.sv
// Port checks for the lane steering block
`default_nettype none
module lane_steering_checker (
   input wire logic sys_clk,
   input wire logic reset_n,
   input wire logic [2:0] memory_type_select,
   input wire logic req_valid,
   input wire logic req_ready,
   input wire logic req_write,
   input wire logic [1:0] req_size,
   input wire logic [21:0] req_addr,
   input wire logic [15:0] req_wdata_hi,
   input wire logic [15:0] req_wdata_lo,
   input wire logic mem_strobe,
   input wire logic mem_write,
   input wire logic mem_data_oe,
   input wire logic [21:0] mem_addr,
   input wire logic [3:0] byte_lane_enable_n,
   input wire logic [31:0] mem_data_out,
   input wire logic mem_ack
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] mt;
   logic [1:0] sz;
   logic [1:0] cnt;
   logic [21:0] a;
   logic [31:0] wd;
   logic wr;
   wire take = req_valid && req_ready;
   wire w32 = mt == 3'h2 || mt == 3'h3 || mt == 3'h4;
   wire bad = req_size == 2'h3 || memory_type_select == 3'h0 || memory_type_select > 3'h4;
   always_ff @(posedge sys_clk) begin
      if (take) begin
         mt <= memory_type_select;
         sz <= req_size;
         a <= req_addr;
         wd <= {req_wdata_hi, req_wdata_lo};
         wr <= req_write;
         cnt <= 2'h0;
      end else if (mem_strobe) begin
         cnt <= cnt + 2'h1;
      end
   end
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   sequence sq_first_ack;
      $rose(mem_ack) && cnt == 2'h1 && !w32 && sz == 2'h2;
   endsequence
   AST_STROBE: assert property (take && !bad |=> mem_strobe)
      else $error("no strobe");
   AST_REFUSE: assert property (take && bad |=> !mem_strobe [*3])
      else $error("strobe on refused request");
   AST_W32: assert property (mem_strobe && w32 && sz == 2'h2
      |-> byte_lane_enable_n == 4'h0 && mem_addr == {a[21:2], 2'h0}) else $error("wide word");
   AST_SWAP: assert property (mem_strobe && w32 && sz == 2'h2 && wr
      |-> mem_data_out == (a[1] ? {wd[15:0], wd[31:16]} : wd)) else $error("word lanes");
   AST_HALF: assert property (mem_strobe && w32 && sz == 2'h1
      |-> byte_lane_enable_n == (a[1] ? 4'hc : 4'h3)) else $error("half enables");
   AST_BYTE32: assert property (mem_strobe && w32 && sz == 2'h0 && wr
      |-> byte_lane_enable_n == ~(4'h8 >> a[1:0])) else $error("byte enables");
   AST_W16: assert property (mem_strobe && !w32 && !(sz == 2'h0 && wr)
      |-> byte_lane_enable_n == 4'hc) else $error("narrow enables");
   AST_BYTE16: assert property (mem_strobe && !w32 && sz == 2'h0 && wr
      |-> byte_lane_enable_n == (a[0] ? 4'he : 4'hd)) else $error("narrow byte enables");
   AST_D16: assert property (mem_strobe && !w32 && sz == 2'h2 && wr
      |-> mem_data_out[15:0] == (cnt == 2'h0 ? wd[31:16] : wd[15:0])) else $error("split data");
   AST_SECOND: assert property (mem_strobe && cnt == 2'h1
      |-> mem_addr == {a[21:1] + (a[1] ? 21'h1fffff : 21'h1), 1'b0}) else $error("second addr");
   AST_GAP: assert property (sq_first_ack |-> ##3 mem_strobe)
      else $error("second transfer late");
   AST_STAND: assert property (mem_strobe
      |=> ($stable(mem_addr) && $stable(byte_lane_enable_n)) [*2]) else $error("addr moved");
   AST_OE: assert property (mem_strobe
      |-> mem_write == wr && mem_data_oe == wr) else $error("transfer direction");
endmodule // lane_steering_checker
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the lane steering block
`default_nettype none
`define CHK(g, e) begin \
   checks_done++; \
   if ((g) !== (e)) begin \
      errors++; \
      $display("wrong value at %0t: got %h expected %h", $time, g, e); \
   end \
end
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic [2:0] memory_type_select = 3'h2;
   logic req_valid = 1'b0;
   logic req_write = 1'b0;
   logic rsp_ready = 1'b0;
   logic [1:0] req_size = 2'h0;
   logic [21:0] req_addr = 22'h0;
   logic [15:0] req_wdata_hi = 16'h0;
   logic [15:0] req_wdata_lo = 16'h0;
   wire req_ready, rsp_valid, rsp_write, rsp_error, mem_strobe, mem_write, mem_data_oe, mem_ack;
   wire [15:0] rsp_data_hi, rsp_data_lo;
   wire [21:0] mem_addr;
   wire [3:0] byte_lane_enable_n;
   wire [31:0] mem_data_out, mem_data_in;
   wire wide = memory_type_select != 3'h1;
   int errors = 0;
   int checks_done = 0;
   lane_steering dut_u (.*);
   lane_mem_model mem_u (.*);
   always #10 sys_clk = ~sys_clk;
   task automatic op(input logic [2:0] t, input logic w, input logic [1:0] s,
                     input logic [21:0] a, input logic [15:0] h, input logic [15:0] l);
      int k;
      k = 0;
      @(negedge sys_clk);
      memory_type_select = t;
      req_write = w;
      req_size = s;
      req_addr = a;
      req_wdata_hi = h;
      req_wdata_lo = l;
      req_valid = 1'b1;
      do @(posedge sys_clk); while (req_ready !== 1'b1 && ++k < 300);
      @(negedge sys_clk);
      req_valid = 1'b0;
   endtask
   task automatic get(input logic w, input logic e, input logic [15:0] h, input logic [15:0] l);
      int k;
      k = 0;
      while (rsp_valid !== 1'b1 && k++ < 300) @(negedge sys_clk);
      `CHK(rsp_valid, 1'b1)
      `CHK(rsp_write, w)
      `CHK(rsp_error, e)
      `CHK(rsp_data_hi, h)
      `CHK(rsp_data_lo, l)
      rsp_ready = 1'b1;
      @(negedge sys_clk);
      rsp_ready = 1'b0;
   endtask
   task automatic xfer(input logic [2:0] t, input logic w, input logic [1:0] s,
                       input logic [21:0] a, input logic [15:0] h, input logic [15:0] l,
                       input logic [15:0] eh, input logic [15:0] el);
      op(t, w, s, a, h, l);
      get(w, 1'b0, eh, el);
   endtask
   task automatic t_wide;
      xfer(3'h2, 1'b1, 2'h2, 22'h10, 16'h1111, 16'h2222, 16'h0, 16'h0);
      xfer(3'h2, 1'b0, 2'h1, 22'h12, 16'h0, 16'h0, 16'h0, 16'h2222);
      xfer(3'h3, 1'b1, 2'h2, 22'h16, 16'h3333, 16'h4444, 16'h0, 16'h0);
      xfer(3'h4, 1'b0, 2'h1, 22'h14, 16'h0, 16'h0, 16'h0, 16'h4444);
      xfer(3'h2, 1'b0, 2'h2, 22'h16, 16'h0, 16'h0, 16'h3333, 16'h4444);
      xfer(3'h2, 1'b1, 2'h1, 22'h1a, 16'h0, 16'hbeef, 16'h0, 16'h0);
      xfer(3'h2, 1'b0, 2'h2, 22'h18, 16'h0, 16'h0, 16'h1819, 16'hbeef);
      for (int i = 0; i < 4; i++) begin
         xfer(3'h2, 1'b1, 2'h0, {20'h8, 2'(i)}, 16'h0, {14'h28, 2'(i)}, 16'h0, 16'h0);
      end
      xfer(3'h2, 1'b0, 2'h2, 22'h20, 16'h0, 16'h0, 16'ha0a1, 16'ha2a3);
      xfer(3'h2, 1'b0, 2'h0, 22'h23, 16'h0, 16'h0, 16'h0, 16'h00a3);
   endtask
   task automatic t_narrow;
      xfer(3'h1, 1'b1, 2'h2, 22'h40, 16'h5555, 16'h6666, 16'h0, 16'h0);
      xfer(3'h1, 1'b0, 2'h1, 22'h42, 16'h0, 16'h0, 16'h0, 16'h6666);
      xfer(3'h1, 1'b1, 2'h2, 22'h4a, 16'h7777, 16'h8888, 16'h0, 16'h0);
      xfer(3'h1, 1'b0, 2'h1, 22'h48, 16'h0, 16'h0, 16'h0, 16'h8888);
      xfer(3'h1, 1'b0, 2'h2, 22'h4a, 16'h0, 16'h0, 16'h7777, 16'h8888);
      xfer(3'h1, 1'b1, 2'h0, 22'h51, 16'h0, 16'h00c1, 16'h0, 16'h0);
      xfer(3'h1, 1'b0, 2'h1, 22'h50, 16'h0, 16'h0, 16'h0, 16'h50c1);
      xfer(3'h1, 1'b0, 2'h0, 22'h50, 16'h0, 16'h0, 16'h0, 16'h0050);
   endtask
   task automatic t_refuse;
      logic [2:0] bad [4] = '{3'h0, 3'h5, 3'h6, 3'h7};
      foreach (bad[i]) begin
         op(bad[i], 1'b0, 2'h1, 22'h10, 16'h0, 16'h0);
         get(1'b0, 1'b1, 16'h0, 16'h0);
      end
      op(3'h2, 1'b1, 2'h3, 22'h10, 16'h0, 16'h0);
      get(1'b1, 1'b1, 16'h0, 16'h0);
   endtask
   task automatic t_buffer;
      mem_u.lat = 6;
      repeat (3) op(3'h2, 1'b0, 2'h1, 22'h12, 16'h0, 16'h0);
      repeat (30) @(negedge sys_clk);
      `CHK(req_ready, 1'b0)
      repeat (3) get(1'b0, 1'b0, 16'h0, 16'h2222);
      mem_u.lat = 1;
   endtask
   task automatic complete_run;
      $display("checks %0d errors %0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk);
      reset_n = 1'b1;
      t_wide;
      t_narrow;
      t_refuse;
      t_buffer;
      complete_run;
   end
   initial begin
      #1000000;
      errors++;
      complete_run;
   end
endmodule // tb_top
bind lane_steering lane_steering_checker chk_u (.*);
`default_nettype wire
